// ---- bench/host_model.sv ----
// Purpose: host side of the register port, one strobe per access
// Assumes: strobes change just after a rising edge
// Notes:   the read data stands from the edge after the strobe
module host_model (
    // clock
    input  wire logic       clk,
    // register port
    output logic            regRead,
    output logic            regWrite,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWriteData
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        regRead = 1'b0;
        regWrite = 1'b0;
        regAddr = 8'h00;
        regWriteData = 8'h00;
    end
    // one-cycle strobe, then one idle edge so data has settled
    task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regRead <= !wr;
        regWrite <= wr;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clk);
        regRead <= 1'b0;
        regWrite <= 1'b0;
        @(posedge clk);
    endtask
endmodule

// ---- bench/testbench.sv ----
// Purpose: scenario tasks for the status and reporting register group
// Assumes: host model drives the register port
// Notes:   events are single-cycle pulses
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset = 1'b1, regRead, regWrite, impedanceValid = 1'b0;
    logic waveformPlaying = 1'b0, interruptMode = 1'b0, interruptPinOut, interruptPinOe;
    logic [7:0] regAddr, regWriteData, regReadData, impedanceIn = 8'h00, supplyIn = 8'h00;
    logic [9:0] periodIn = 10'h000;
    logic [5:0] evt = 6'h00;
    int n_mismatch = 0;
    int cmp_count = 0;
    always #2.5 clk = ~clk;
    host_model host_u (.clk(clk), .regRead(regRead), .regWrite(regWrite), .regAddr(regAddr),
        .regWriteData(regWriteData));
    haptic_status_regs dut_u (.clk(clk), .reset(reset), .regRead(regRead), .regWrite(regWrite),
        .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
        .processDone(evt[3]), .undervoltageEvent(evt[2]), .overtempEvent(evt[1]),
        .overcurrentEvent(evt[0]), .diagnosticFailEvent(evt[5]), .formatErrorEvent(evt[4]),
        .impedanceValid(impedanceValid), .impedanceIn(impedanceIn),
        .waveformPlaying(waveformPlaying), .supplyIn(supplyIn), .periodIn(periodIn),
        .interruptMode(interruptMode), .interruptPinOut(interruptPinOut),
        .interruptPinOe(interruptPinOe));
    task automatic complete_run();
        if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        host_u.access(1'b0, a, 8'h00);
        check(regReadData, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge clk);
        evt[i] <= 1'b1;
        @(posedge clk);
        evt[i] <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    task automatic pin_is(input logic exp);
        check({7'h00, interruptPinOe}, {7'h00, exp});
    endtask
    task automatic reset_values();
        rd(haptic_status_pkg::ADDR_MASK, 8'h18);
        rd(haptic_status_pkg::ADDR_FLAGS, 8'h00);
        rd(haptic_status_pkg::ADDR_IMPEDANCE, 8'h00);
        rd(haptic_status_pkg::ADDR_SUPPLY, 8'h00);
        rd(8'h3C, 8'h00);
    endtask
    task automatic sticky_flags();
        for (int i = 0; i < 6; i++) begin
            pulse(i);
            rd(haptic_status_pkg::ADDR_FLAGS, 8'h01 << ((i < 5) ? i : 7));
            rd(haptic_status_pkg::ADDR_FLAGS, 8'h00);
        end
    endtask
    task automatic interrupt_pin();
        interruptMode <= 1'b1;
        pulse(3);
        pin_is(1'b1);
        rd(haptic_status_pkg::ADDR_FLAGS, 8'h08);
        pulse(0);
        pin_is(1'b0);
        rd(haptic_status_pkg::ADDR_FLAGS, 8'h01);
        repeat (2) @(posedge clk);
        pin_is(1'b1);
        interruptMode <= 1'b0;
        pulse(0);
        pin_is(1'b1);
        rd(haptic_status_pkg::ADDR_FLAGS, 8'h01);
        host_u.access(1'b1, haptic_status_pkg::ADDR_MASK, 8'hFF);
        rd(haptic_status_pkg::ADDR_MASK, 8'h1F);
        interruptMode <= 1'b1;
        pulse(1);
        pin_is(1'b1);
        rd(haptic_status_pkg::ADDR_FLAGS, 8'h02);
        host_u.access(1'b1, haptic_status_pkg::ADDR_MASK, 8'h00);
        pulse(2);
        pin_is(1'b0);
        rd(haptic_status_pkg::ADDR_FLAGS, 8'h04);
    endtask
    task automatic reset_again();
        pulse(0);
        pin_is(1'b0);
        @(posedge clk);
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        check({7'h00, interruptPinOut}, 8'h01);
        pin_is(1'b1);
        reset <= 1'b0;
        rd(haptic_status_pkg::ADDR_MASK, 8'h18);
        rd(haptic_status_pkg::ADDR_FLAGS, 8'h00);
        check({7'h00, interruptPinOut}, 8'h00);
    endtask
    task automatic read_race();
        fork
            rd(haptic_status_pkg::ADDR_FLAGS, 8'h00);
            pulse(3);
        join
        rd(haptic_status_pkg::ADDR_FLAGS, 8'h08);
    endtask
    task automatic measurements();
        @(posedge clk);
        impedanceIn <= 8'h7E;
        impedanceValid <= 1'b1;
        @(posedge clk);
        impedanceValid <= 1'b0;
        host_u.access(1'b1, haptic_status_pkg::ADDR_IMPEDANCE, 8'hFF);
        rd(haptic_status_pkg::ADDR_IMPEDANCE, 8'h7E);
        waveformPlaying <= 1'b1;
        supplyIn <= 8'h5A;
        periodIn <= 10'h2A5;
        rd(haptic_status_pkg::ADDR_SUPPLY, 8'h5A);
        rd(haptic_status_pkg::ADDR_PERIOD_HI, 8'h02);
        periodIn <= 10'h1C3;
        rd(haptic_status_pkg::ADDR_PERIOD_LO, 8'hA5);
        rd(haptic_status_pkg::ADDR_PERIOD_HI, 8'h01);
        rd(haptic_status_pkg::ADDR_PERIOD_LO, 8'hC3);
        waveformPlaying <= 1'b0;
        supplyIn <= 8'h33;
        rd(haptic_status_pkg::ADDR_SUPPLY, 8'h5A);
        waveformPlaying <= 1'b1;
        periodIn <= 10'h0F0;
        rd(haptic_status_pkg::ADDR_PERIOD_HI, 8'h00);
        waveformPlaying <= 1'b0;
        periodIn <= 10'h30F;
        @(posedge clk);
        waveformPlaying <= 1'b1;
        rd(haptic_status_pkg::ADDR_PERIOD_LO, 8'h0F);
        rd(haptic_status_pkg::ADDR_PERIOD_HI, 8'h03);
        rd(haptic_status_pkg::ADDR_SUPPLY, 8'h33);
        waveformPlaying <= 1'b0;
    endtask
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        reset_values();
        sticky_flags();
        interrupt_pin();
        reset_again();
        read_race();
        measurements();
        complete_run();
    end
endmodule

// ---- logic/haptic_status_pkg.sv ----
// Purpose: constants for the haptic status and reporting register group
// Assumes: byte-wide register port, device clock at 200 MHz
// Notes:   offsets are the register addresses on the serial register interface
package haptic_status_pkg;
    localparam logic [7:0] ADDR_FLAGS     = 8'h01;
    localparam logic [7:0] ADDR_MASK      = 8'h02;
    localparam logic [7:0] ADDR_IMPEDANCE = 8'h03;
    localparam logic [7:0] ADDR_SUPPLY    = 8'h04;
    localparam logic [7:0] ADDR_PERIOD_HI = 8'h05;
    localparam logic [7:0] ADDR_PERIOD_LO = 8'h06;

    localparam int BIT_OVERCURRENT = 0;
    localparam int BIT_OVERTEMP    = 1;
    localparam int BIT_UNDERVOLT   = 2;
    localparam int BIT_DONE        = 3;
    localparam int BIT_FORMAT_ERR  = 4;
    localparam int BIT_DIAG_FAIL   = 7;
    localparam int MASK_WIDTH      = 5;
    localparam int PERIOD_WIDTH    = 10;

    localparam logic [4:0] MASK_RESET      = 5'h18;
    localparam logic [7:0] FLAGS_RESET     = 8'h00;
    localparam logic [7:0] IMPEDANCE_RESET = 8'h00;
    localparam logic [7:0] SUPPLY_RESET    = 8'h00;
    localparam logic [9:0] PERIOD_RESET    = 10'h000;

    // period report unit, nanoseconds per count
    localparam real PERIOD_UNIT_NS = 24390.0;
    localparam real CLOCK_PERIOD_NS = 5.0;
    localparam int  PERIOD_UNIT_CYCLES = int'(PERIOD_UNIT_NS / CLOCK_PERIOD_NS);
endpackage

// ---- logic/haptic_status_regs.sv ----
// Purpose: sticky status flags, interrupt mask, impedance, supply and period report
// Assumes: register port is a one-cycle read or write strobe with address, byte data
// Notes:   read data is registered and valid the cycle after the read strobe
module haptic_status_regs (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // register port
    input  wire logic       regRead,
    input  wire logic       regWrite,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWriteData,
    output logic      [7:0] regReadData,
    // event sources
    input  wire logic       processDone,
    input  wire logic       undervoltageEvent,
    input  wire logic       overtempEvent,
    input  wire logic       overcurrentEvent,
    input  wire logic       diagnosticFailEvent,
    input  wire logic       formatErrorEvent,
    // measurements
    input  wire logic       impedanceValid,
    input  wire logic [7:0] impedanceIn,
    input  wire logic       waveformPlaying,
    input  wire logic [7:0] supplyIn,
    input  wire logic [9:0] periodIn,
    // pin control
    input  wire logic       interruptMode,
    output logic            interruptPinOut,
    output logic            interruptPinOe
);
    logic [7:0] flags;
    logic [4:0] interruptSourceMask;
    logic [7:0] impedanceResult;
    logic [7:0] supplyReading;
    logic [9:0] periodReport;
    logic       periodLocked;
    logic [7:0] eventBits;
    logic [3:0] pending;
    logic       flagsRead;
    logic       next_interruptActive;

    assign eventBits = {diagnosticFailEvent, 2'b00, formatErrorEvent, processDone,
                        undervoltageEvent, overtempEvent, overcurrentEvent};
    assign flagsRead = regRead && (regAddr == haptic_status_pkg::ADDR_FLAGS);

    // sticky flags, set wins over read clear
    always_ff @(posedge clk) begin
        if (reset) begin
            flags <= haptic_status_pkg::FLAGS_RESET;
        end else if (flagsRead) begin
            flags <= eventBits;
        end else begin
            flags <= flags | eventBits;
        end
    end

    flag_set_a: assert property (@(posedge clk) disable iff (reset)
        overtempEvent |=> flags[haptic_status_pkg::BIT_OVERTEMP])
        else $error("overtemp flag not set");
    oc_set_a: assert property (@(posedge clk) disable iff (reset)
        overcurrentEvent |=> flags[haptic_status_pkg::BIT_OVERCURRENT])
        else $error("overcurrent flag not set");
    uv_set_a: assert property (@(posedge clk) disable iff (reset)
        undervoltageEvent |=> flags[haptic_status_pkg::BIT_UNDERVOLT])
        else $error("undervoltage flag not set");
    done_set_a: assert property (@(posedge clk) disable iff (reset)
        processDone |=> flags[haptic_status_pkg::BIT_DONE])
        else $error("completion flag not set");
    diag_set_a: assert property (@(posedge clk) disable iff (reset)
        diagnosticFailEvent |=> flags[haptic_status_pkg::BIT_DIAG_FAIL])
        else $error("diagnostic fail flag not set");
    format_set_a: assert property (@(posedge clk) disable iff (reset)
        formatErrorEvent |=> flags[haptic_status_pkg::BIT_FORMAT_ERR])
        else $error("format error flag not set");
    flag_hold_a: assert property (@(posedge clk) disable iff (reset)
        (flags[haptic_status_pkg::BIT_OVERCURRENT] && !flagsRead)
        |=> flags[haptic_status_pkg::BIT_OVERCURRENT])
        else $error("overcurrent flag lost without read");
    temp_hold_a: assert property (@(posedge clk) disable iff (reset)
        (flags[haptic_status_pkg::BIT_OVERTEMP] && !flagsRead)
        |=> flags[haptic_status_pkg::BIT_OVERTEMP])
        else $error("overtemp flag lost without read");
    uv_hold_a: assert property (@(posedge clk) disable iff (reset)
        (flags[haptic_status_pkg::BIT_UNDERVOLT] && !flagsRead)
        |=> flags[haptic_status_pkg::BIT_UNDERVOLT])
        else $error("undervoltage flag lost without read");
    done_hold_a: assert property (@(posedge clk) disable iff (reset)
        (flags[haptic_status_pkg::BIT_DONE] && !flagsRead)
        |=> flags[haptic_status_pkg::BIT_DONE])
        else $error("completion flag lost without read");
    diag_hold_a: assert property (@(posedge clk) disable iff (reset)
        (flags[haptic_status_pkg::BIT_DIAG_FAIL] && !flagsRead)
        |=> flags[haptic_status_pkg::BIT_DIAG_FAIL])
        else $error("diagnostic fail flag lost without read");
    format_hold_a: assert property (@(posedge clk) disable iff (reset)
        (flags[haptic_status_pkg::BIT_FORMAT_ERR] && !flagsRead)
        |=> flags[haptic_status_pkg::BIT_FORMAT_ERR])
        else $error("format error flag lost without read");
    read_clear_a: assert property (@(posedge clk) disable iff (reset)
        (flagsRead && !undervoltageEvent) |=> !flags[haptic_status_pkg::BIT_UNDERVOLT])
        else $error("undervoltage flag not cleared by read");
    oc_clear_a: assert property (@(posedge clk) disable iff (reset)
        (flagsRead && !overcurrentEvent) |=> !flags[haptic_status_pkg::BIT_OVERCURRENT])
        else $error("overcurrent flag not cleared by read");
    temp_clear_a: assert property (@(posedge clk) disable iff (reset)
        (flagsRead && !overtempEvent) |=> !flags[haptic_status_pkg::BIT_OVERTEMP])
        else $error("overtemp flag not cleared by read");
    done_clear_a: assert property (@(posedge clk) disable iff (reset)
        (flagsRead && !processDone) |=> !flags[haptic_status_pkg::BIT_DONE])
        else $error("completion flag not cleared by read");
    diag_clear_a: assert property (@(posedge clk) disable iff (reset)
        (flagsRead && !diagnosticFailEvent) |=> !flags[haptic_status_pkg::BIT_DIAG_FAIL])
        else $error("diagnostic fail flag not cleared by read");
    format_clear_a: assert property (@(posedge clk) disable iff (reset)
        (flagsRead && !formatErrorEvent) |=> !flags[haptic_status_pkg::BIT_FORMAT_ERR])
        else $error("format error flag not cleared by read");
    done_survive_a: assert property (@(posedge clk) disable iff (reset)
        (flagsRead && processDone) |=> flags[haptic_status_pkg::BIT_DONE])
        else $error("completion event lost on read");
    oc_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (!flags[haptic_status_pkg::BIT_OVERCURRENT] && !overcurrentEvent)
        |=> !flags[haptic_status_pkg::BIT_OVERCURRENT])
        else $error("overcurrent flag set without event");
    temp_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (!flags[haptic_status_pkg::BIT_OVERTEMP] && !overtempEvent)
        |=> !flags[haptic_status_pkg::BIT_OVERTEMP])
        else $error("overtemp flag set without event");
    uv_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (!flags[haptic_status_pkg::BIT_UNDERVOLT] && !undervoltageEvent)
        |=> !flags[haptic_status_pkg::BIT_UNDERVOLT])
        else $error("undervoltage flag set without event");
    done_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (!flags[haptic_status_pkg::BIT_DONE] && !processDone)
        |=> !flags[haptic_status_pkg::BIT_DONE])
        else $error("completion flag set without event");
    diag_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (!flags[haptic_status_pkg::BIT_DIAG_FAIL] && !diagnosticFailEvent)
        |=> !flags[haptic_status_pkg::BIT_DIAG_FAIL])
        else $error("diagnostic fail flag set without event");
    format_quiet_a: assert property (@(posedge clk) disable iff (reset)
        (!flags[haptic_status_pkg::BIT_FORMAT_ERR] && !formatErrorEvent)
        |=> !flags[haptic_status_pkg::BIT_FORMAT_ERR])
        else $error("format error flag set without event");

    // mask register
    always_ff @(posedge clk) begin
        if (reset) begin
            interruptSourceMask <= haptic_status_pkg::MASK_RESET;
        end else if (regWrite && regAddr == haptic_status_pkg::ADDR_MASK) begin
            interruptSourceMask <= regWriteData[4:0];
        end
    end

    mask_write_a: assert property (@(posedge clk) disable iff (reset)
        (regWrite && regAddr == haptic_status_pkg::ADDR_MASK)
        |=> interruptSourceMask == $past(regWriteData[4:0]))
        else $error("mask write not stored");
    mask_keep_a: assert property (@(posedge clk) disable iff (reset)
        !(regWrite && regAddr == haptic_status_pkg::ADDR_MASK) |=> $stable(interruptSourceMask))
        else $error("mask changed without write");

    // impedance result
    always_ff @(posedge clk) begin
        if (reset) begin
            impedanceResult <= haptic_status_pkg::IMPEDANCE_RESET;
        end else if (impedanceValid) begin
            impedanceResult <= impedanceIn;
        end
    end

    impedance_a: assert property (@(posedge clk) disable iff (reset)
        impedanceValid |=> impedanceResult == $past(impedanceIn))
        else $error("impedance not captured");
    impedance_keep_a: assert property (@(posedge clk) disable iff (reset)
        !impedanceValid |=> $stable(impedanceResult))
        else $error("impedance changed without new result");

    // supply reading
    always_ff @(posedge clk) begin
        if (reset) begin
            supplyReading <= haptic_status_pkg::SUPPLY_RESET;
        end else if (waveformPlaying) begin
            supplyReading <= supplyIn;
        end
    end

    supply_hold_a: assert property (@(posedge clk) disable iff (reset)
        !waveformPlaying |=> $stable(supplyReading))
        else $error("supply reading changed while idle");
    supply_track_a: assert property (@(posedge clk) disable iff (reset)
        waveformPlaying |=> supplyReading == $past(supplyIn))
        else $error("supply reading not updated while playing");

    // period report with read lock
    always_ff @(posedge clk) begin
        if (reset) begin
            periodLocked <= 1'b0;
        end else if (regRead && regAddr == haptic_status_pkg::ADDR_PERIOD_HI) begin
            periodLocked <= 1'b1;
        end else if (!waveformPlaying ||
                     (regRead && regAddr == haptic_status_pkg::ADDR_PERIOD_LO)) begin
            periodLocked <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            periodReport <= haptic_status_pkg::PERIOD_RESET;
        end else if (waveformPlaying && !periodLocked &&
                     !(regRead && regAddr == haptic_status_pkg::ADDR_PERIOD_HI)) begin
            periodReport <= periodIn;
        end
    end

    period_lock_a: assert property (@(posedge clk) disable iff (reset)
        (regRead && regAddr == haptic_status_pkg::ADDR_PERIOD_HI) |=> $stable(periodReport))
        else $error("period changed after high byte read");
    lock_set_a: assert property (@(posedge clk) disable iff (reset)
        (regRead && regAddr == haptic_status_pkg::ADDR_PERIOD_HI) |=> periodLocked)
        else $error("period lock not taken");
    lock_release_a: assert property (@(posedge clk) disable iff (reset)
        (!waveformPlaying && !(regRead && regAddr == haptic_status_pkg::ADDR_PERIOD_HI))
        |=> !periodLocked)
        else $error("period lock kept after waveform end");
    locked_hold_a: assert property (@(posedge clk) disable iff (reset)
        periodLocked |=> $stable(periodReport))
        else $error("period changed while locked");
    period_track_a: assert property (@(posedge clk) disable iff (reset)
        (waveformPlaying && !periodLocked &&
         !(regRead && regAddr == haptic_status_pkg::ADDR_PERIOD_HI))
        |=> periodReport == $past(periodIn))
        else $error("period not tracked while unlocked");

    // read data
    always_ff @(posedge clk) begin
        if (reset) begin
            regReadData <= 8'h00;
        end else if (regRead) begin
            case (regAddr)
                haptic_status_pkg::ADDR_FLAGS:     regReadData <= flags;
                haptic_status_pkg::ADDR_MASK:      regReadData <= {3'b000, interruptSourceMask};
                haptic_status_pkg::ADDR_IMPEDANCE: regReadData <= impedanceResult;
                haptic_status_pkg::ADDR_SUPPLY:    regReadData <= supplyReading;
                haptic_status_pkg::ADDR_PERIOD_HI: regReadData <= {6'h00, periodReport[9:8]};
                haptic_status_pkg::ADDR_PERIOD_LO: regReadData <= periodReport[7:0];
                default:                           regReadData <= 8'h00;
            endcase
        end
    end

    read_value_a: assert property (@(posedge clk) disable iff (reset)
        flagsRead |=> regReadData == $past(flags))
        else $error("flag read returned wrong value");
    period_high_a: assert property (@(posedge clk) disable iff (reset)
        (regRead && regAddr == haptic_status_pkg::ADDR_PERIOD_HI) |=> regReadData[7:2] == 6'h00)
        else $error("reserved period bits not zero");
    mask_read_a: assert property (@(posedge clk) disable iff (reset)
        (regRead && regAddr == haptic_status_pkg::ADDR_MASK)
        |=> regReadData == {3'b000, $past(interruptSourceMask)})
        else $error("mask read returned wrong value");
    period_low_a: assert property (@(posedge clk) disable iff (reset)
        (regRead && regAddr == haptic_status_pkg::ADDR_PERIOD_LO)
        |=> regReadData == $past(periodReport[7:0]))
        else $error("low period read returned wrong value");
    read_hold_a: assert property (@(posedge clk) disable iff (reset)
        !regRead |=> $stable(regReadData))
        else $error("read data changed without read");
    supply_read_a: assert property (@(posedge clk) disable iff (reset)
        (regRead && regAddr == haptic_status_pkg::ADDR_SUPPLY)
        |=> regReadData == $past(supplyReading))
        else $error("supply read returned wrong value");
    impedance_read_a: assert property (@(posedge clk) disable iff (reset)
        (regRead && regAddr == haptic_status_pkg::ADDR_IMPEDANCE)
        |=> regReadData == $past(impedanceResult))
        else $error("impedance read returned wrong value");

    // interrupt pin, open drain: oe low means pulling low
    assign pending = flags[3:0] & ~interruptSourceMask[3:0];
    assign next_interruptActive = interruptMode && (|pending);

    always_ff @(posedge clk) begin
        if (reset) begin
            interruptPinOut <= 1'b1;
            interruptPinOe  <= 1'b1;
        end else begin
            interruptPinOut <= 1'b0;
            interruptPinOe  <= !next_interruptActive;
        end
    end

    irq_pin_a: assert property (@(posedge clk) disable iff (reset)
        (interruptMode && flags[0] && !interruptSourceMask[0]) |=> !interruptPinOe)
        else $error("interrupt pin not driven");
    irq_mode_a: assert property (@(posedge clk) disable iff (reset)
        !interruptMode |=> interruptPinOe)
        else $error("interrupt driven outside interrupt mode");
    irq_masked_a: assert property (@(posedge clk) disable iff (reset)
        (pending == 4'h0) |=> interruptPinOe)
        else $error("masked flag raised interrupt");
    pin_low_a: assert property (@(posedge clk) disable iff (reset)
        !$past(reset) |-> !interruptPinOut)
        else $error("interrupt pin level not low");
    irq_follow_a: assert property (@(posedge clk) disable iff (reset)
        next_interruptActive |=> !interruptPinOe)
        else $error("pending interrupt not driven");
    irq_uv_a: assert property (@(posedge clk) disable iff (reset)
        (interruptMode && flags[haptic_status_pkg::BIT_UNDERVOLT] && !interruptSourceMask[2])
        |=> !interruptPinOe)
        else $error("unmasked undervoltage not driven");
endmodule
